// *** rtl/tsb_params.svh ***
// Offsets, field positions, codes and sizes of the status block builder.
`ifndef TSB_PARAMS_SVH
`define TSB_PARAMS_SVH

`define TSB_OFS_CMD 8'h00
`define TSB_OFS_CHAN 8'h04
`define TSB_OFS_RESULT 8'h08
`define TSB_OFS_CNT_LO 8'h0C
`define TSB_OFS_CNT_HI 8'h10
`define TSB_OFS_PEER 8'h14
`define TSB_OFS_WQCAP 8'h18
`define TSB_OFS_RQCAP 8'h1C
`define TSB_OFS_STAT 8'h20

`define TSB_FN_WRITE 8'h00
`define TSB_FN_READ 8'h40
`define TSB_FN_NOTICE 8'h42
`define TSB_FN_OPEN 8'hC1
`define TSB_FN_CLOSE 8'hC2

`define TSB_KIND_WRITE 3'h0
`define TSB_KIND_READ 3'h1
`define TSB_KIND_NOTICE 3'h2
`define TSB_KIND_OPEN 3'h3
`define TSB_KIND_CLOSE 3'h4

`define TSB_MGMT_ID 16'hFFFF
`define TSB_RESULT_OK 7'h00
`define TSB_CMD_ALLOW_BIT 8
`define TSB_RES_OOB_BIT 8
`define TSB_BLK_WORDS 6
`define TSB_IDX_LAST 3'h5
`define TSB_WQ_CAP 32'h0000_0008
`define TSB_RQ_CAP 32'h0000_0008
`define TSB_RESP_OKAY 2'h0
`define TSB_RESP_DECERR 2'h3

`endif

// *** rtl/tsb_pkg.sv ***
// Types shared by the status block builder modules.
`include "tsb_params.svh"
package tsb_pkg;
  typedef logic [31:0] tsb_word_t;
  typedef logic [2:0] tsb_kind_t;
  typedef struct packed {
    tsb_kind_t kind;
    logic [7:0] initiator_process_id;
    logic [7:0] target_endpoint_id;
    logic [6:0] status;
    logic oob;
    logic [15:0] cnt_hi;
    logic [31:0] cnt_lo;
    logic [7:0] peer_initiator_process_id;
    logic [7:0] peer_target_endpoint_id;
  } tsb_req_s;
endpackage

// *** rtl/tsb_regbus_if.sv ***
// Register access strobes between the bus slave and the block core.
interface tsb_regbus_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 input wr_err, rd_data, rd_err);
  modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface

// *** rtl/tsb_block_format.sv ***
// Combinational layout of the six status block quadlets from one request.
module tsb_block_format
  import tsb_pkg::*;
#(
  parameter logic [31:0] WQ_CAP = `TSB_WQ_CAP,
  parameter logic [31:0] RQ_CAP = `TSB_RQ_CAP
) (
  input tsb_req_s req,
  output tsb_word_t words [`TSB_BLK_WORDS]
);
  always_comb begin
    for (int i = 0; i < `TSB_BLK_WORDS; i++) begin
      words[i] = 32'h0000_0000;
    end
    unique case (req.kind)
      `TSB_KIND_READ: begin
        words[0] = {req.initiator_process_id, req.target_endpoint_id, `TSB_FN_READ, req.oob, req.status};
        words[1] = {16'h0000, req.cnt_hi};
        words[2] = req.cnt_lo;
      end
      `TSB_KIND_NOTICE: begin
        words[0] = {req.initiator_process_id, req.target_endpoint_id, `TSB_FN_NOTICE, 1'b0, req.status};
        words[1] = {16'h0000, req.cnt_hi};
        words[2] = req.cnt_lo;
      end
      `TSB_KIND_OPEN: begin
        words[0] = {`TSB_MGMT_ID, `TSB_FN_OPEN, 1'b0, req.status};
        words[1] = {req.peer_initiator_process_id, req.peer_target_endpoint_id, 16'h0000};
        words[2] = WQ_CAP;
        words[3] = RQ_CAP;
      end
      `TSB_KIND_CLOSE: begin
        words[0] = {`TSB_MGMT_ID, `TSB_FN_CLOSE, 1'b0, req.status};
        words[1] = {req.peer_initiator_process_id, req.peer_target_endpoint_id, 16'h0000};
      end
      default: begin
        // Only the write kind reaches here; other codes are refused at launch.
        words[0] = {req.initiator_process_id, req.target_endpoint_id, `TSB_FN_WRITE, 1'b0, req.status};
        words[1] = {16'h0000, req.cnt_hi};
        words[2] = req.cnt_lo;
      end
    endcase
  end
endmodule

// *** rtl/tsb_axil_slave.sv ***
// AXI4-Lite slave that turns bus transfers into single-cycle register strobes.
module tsb_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  tsb_regbus_if.slave rb
);
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rb.wr_en = aw_held_q && w_held_q && !s_axi_bvalid;
  assign rb.wr_addr = awaddr_q;
  assign rb.wr_data = wdata_q;
  assign rb.wr_strb = wstrb_q;
  assign rb.rd_en = s_axi_arvalid && s_axi_arready;
  assign rb.rd_addr = {s_axi_araddr[7:2], 2'b00};

  ////////////////////////////////////////////////////////////////////////////
  // Address and data are held separately so they may arrive in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (rb.wr_en) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TSB_RESP_OKAY;
    end else if (rb.wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= rb.wr_err ? `TSB_RESP_DECERR : `TSB_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TSB_RESP_OKAY;
    end else if (rb.rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rb.rd_err ? 32'h0000_0000 : rb.rd_data;
      s_axi_rresp <= rb.rd_err ? `TSB_RESP_DECERR : `TSB_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// *** rtl/tsb_status_builder.sv ***
// Status block builder: register file, launch control and quadlet streaming.
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
module tsb_status_builder
  import tsb_pkg::*;
#(
  parameter logic [31:0] WQ_CAP = `TSB_WQ_CAP,
  parameter logic [31:0] RQ_CAP = `TSB_RQ_CAP
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic blk_valid,
  input wire logic blk_ready,
  output logic [31:0] blk_data,
  output logic blk_last,
  output logic busy
);
  typedef enum logic [1:0] {ST_IDLE, ST_BUILD, ST_SEND} tsb_state_e;

  tsb_regbus_if rb ();

  tsb_state_e state_q;
  logic [15:0] chan_q;
  logic [31:0] result_q;
  logic [31:0] cnt_lo_q;
  logic [15:0] cnt_hi_q;
  logic [15:0] peer_q;
  tsb_kind_t last_kind_q;
  logic refused_q;
  logic allow_q;
  logic [15:0] allow_chan_q;
  tsb_req_s req_q;
  tsb_word_t words [`TSB_BLK_WORDS];
  tsb_word_t buf_q [`TSB_BLK_WORDS];
  logic [2:0] idx_q;
  logic cmd_wr;
  tsb_kind_t cmd_kind;
  logic kind_ok;
  logic notice_ok;
  logic launch;
  logic xfer;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and block formatter.
  tsb_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rb(rb.slave)
  );

  tsb_block_format #(
    .WQ_CAP(WQ_CAP),
    .RQ_CAP(RQ_CAP)
  ) u_format (
    .req(req_q),
    .words(words)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes. Field registers stay writable while a block is sent,
  // because the block works from its own latched copy.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_q <= 16'h0000;
      result_q <= 32'h0000_0000;
      cnt_lo_q <= 32'h0000_0000;
      cnt_hi_q <= 16'h0000;
      peer_q <= 16'h0000;
    end else if (rb.wr_en) begin
      unique case (rb.wr_addr)
        `TSB_OFS_CHAN: chan_q <= 16'(merge({16'h0000, chan_q}, rb.wr_data, rb.wr_strb));
        `TSB_OFS_RESULT: result_q <= merge(result_q, rb.wr_data, rb.wr_strb);
        `TSB_OFS_CNT_LO: cnt_lo_q <= merge(cnt_lo_q, rb.wr_data, rb.wr_strb);
        `TSB_OFS_CNT_HI: cnt_hi_q <= 16'(merge({16'h0000, cnt_hi_q}, rb.wr_data, rb.wr_strb));
        `TSB_OFS_PEER: peer_q <= 16'(merge({16'h0000, peer_q}, rb.wr_data, rb.wr_strb));
        default: begin
        end
      endcase
    end
  end

  assign rb.wr_err = !(rb.wr_addr inside {`TSB_OFS_CMD, `TSB_OFS_CHAN, `TSB_OFS_RESULT,
                       `TSB_OFS_CNT_LO, `TSB_OFS_CNT_HI, `TSB_OFS_PEER, `TSB_OFS_WQCAP,
                       `TSB_OFS_RQCAP, `TSB_OFS_STAT});

  ////////////////////////////////////////////////////////////////////////////
  // Launch decision. A notice is only let through for the channel whose
  // open request allowed notices; anything else is dropped and flagged.
  assign cmd_wr = rb.wr_en && (rb.wr_addr == `TSB_OFS_CMD) && rb.wr_strb[0];
  assign cmd_kind = rb.wr_data[2:0];
  assign kind_ok = cmd_kind inside {`TSB_KIND_WRITE, `TSB_KIND_READ, `TSB_KIND_NOTICE,
                                    `TSB_KIND_OPEN, `TSB_KIND_CLOSE};
  assign notice_ok = allow_q && (allow_chan_q == chan_q);
  assign launch = cmd_wr && (state_q == ST_IDLE) && kind_ok &&
                  ((cmd_kind != `TSB_KIND_NOTICE) || notice_ok);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refused_q <= 1'b0;
      last_kind_q <= `TSB_KIND_WRITE;
    end else if (cmd_wr) begin
      refused_q <= !launch;
      last_kind_q <= cmd_kind;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      allow_q <= 1'b0;
      allow_chan_q <= 16'h0000;
    end else if (launch && cmd_kind == `TSB_KIND_OPEN) begin
      allow_q <= rb.wr_data[`TSB_CMD_ALLOW_BIT];
      allow_chan_q <= peer_q;
    end else if (launch && cmd_kind == `TSB_KIND_CLOSE && peer_q == allow_chan_q) begin
      allow_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request latch and sequencing. The whole block is copied into the send
  // buffer before the first quadlet is offered; costs one cycle of latency.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_q <= '0;
    end else if (launch) begin
      req_q.kind <= cmd_kind;
      req_q.initiator_process_id <= chan_q[15:8];
      req_q.target_endpoint_id <= chan_q[7:0];
      req_q.status <= result_q[6:0];
      req_q.oob <= result_q[`TSB_RES_OOB_BIT];
      req_q.cnt_hi <= cnt_hi_q;
      req_q.cnt_lo <= cnt_lo_q;
      req_q.peer_initiator_process_id <= peer_q[15:8];
      req_q.peer_target_endpoint_id <= peer_q[7:0];
    end
  end

  assign xfer = blk_valid && blk_ready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      idx_q <= 3'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: if (launch) state_q <= ST_BUILD;
        ST_BUILD: begin
          state_q <= ST_SEND;
          idx_q <= 3'h0;
        end
        ST_SEND: if (xfer) begin
          idx_q <= idx_q + 3'h1;
          if (blk_last) state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `TSB_BLK_WORDS; i++) buf_q[i] <= 32'h0000_0000;
    end else if (state_q == ST_BUILD) begin
      buf_q <= words;
    end else if (xfer) begin
      for (int i = 0; i < `TSB_BLK_WORDS - 1; i++) buf_q[i] <= buf_q[i+1];
      buf_q[`TSB_BLK_WORDS-1] <= 32'h0000_0000;
    end
  end

  assign blk_valid = (state_q == ST_SEND);
  assign blk_last = blk_valid && (idx_q == `TSB_IDX_LAST);
  assign blk_data = buf_q[0];
  assign busy = (state_q != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Register reads.
  always_comb begin
    rb.rd_err = 1'b0;
    unique case (rb.rd_addr)
      `TSB_OFS_CMD: rb.rd_data = {29'h0000_0000, last_kind_q};
      `TSB_OFS_CHAN: rb.rd_data = {16'h0000, chan_q};
      `TSB_OFS_RESULT: rb.rd_data = result_q;
      `TSB_OFS_CNT_LO: rb.rd_data = cnt_lo_q;
      `TSB_OFS_CNT_HI: rb.rd_data = {16'h0000, cnt_hi_q};
      `TSB_OFS_PEER: rb.rd_data = {16'h0000, peer_q};
      `TSB_OFS_WQCAP: rb.rd_data = WQ_CAP;
      `TSB_OFS_RQCAP: rb.rd_data = RQ_CAP;
      `TSB_OFS_STAT: rb.rd_data = {allow_chan_q, 13'h0000, allow_q, refused_q, busy};
      default: begin
        rb.rd_data = 32'h0000_0000;
        rb.rd_err = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_launch_to_valid: assert property (@(posedge aclk) disable iff (!aresetn)
    launch |-> ##1 !blk_valid ##1 blk_valid && idx_q == 3'h0)
    else $error("Block not offered two cycles after launch.");

  a_hold_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    blk_valid && !blk_ready |=> blk_valid && $stable(blk_data) && $stable(idx_q))
    else $error("Stalled quadlet changed.");

  a_last_sixth: assert property (@(posedge aclk) disable iff (!aresetn)
    blk_valid && blk_ready && blk_last |=> !blk_valid && !busy)
    else $error("Block did not end after the sixth quadlet.");

  a_mgmt_ident: assert property (@(posedge aclk) disable iff (!aresetn)
    blk_valid && idx_q == 3'h0 && req_q.kind inside {`TSB_KIND_OPEN, `TSB_KIND_CLOSE}
    |-> blk_data[31:16] == `TSB_MGMT_ID && blk_data[7] == 1'b0)
    else $error("Management block lacks FFFF identifier or zero tag.");

  a_chan_echo: assert property (@(posedge aclk) disable iff (!aresetn)
    blk_valid && idx_q == 3'h0 && req_q.kind inside {`TSB_KIND_WRITE, `TSB_KIND_READ}
    |-> blk_data[31:16] == {req_q.initiator_process_id, req_q.target_endpoint_id} && blk_data[6:0] == req_q.status)
    else $error("Channel pair or result code wrong.");

  a_tag_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    blk_valid && idx_q == 3'h0 && req_q.kind == `TSB_KIND_WRITE
    |-> blk_data[15:7] == {`TSB_FN_WRITE, 1'b0})
    else $error("Write block function or tag wrong.");

  a_read_tag: assert property (@(posedge aclk) disable iff (!aresetn)
    blk_valid && idx_q == 3'h0 && req_q.kind == `TSB_KIND_READ
    |-> blk_data[15:7] == {`TSB_FN_READ, req_q.oob})
    else $error("Read block function or tag wrong.");

  a_count_low: assert property (@(posedge aclk) disable iff (!aresetn)
    blk_valid && idx_q == 3'h2 && req_q.kind inside {`TSB_KIND_WRITE, `TSB_KIND_READ,
    `TSB_KIND_NOTICE} |-> blk_data == req_q.cnt_lo)
    else $error("Byte count low part wrong.");

  a_open_caps: assert property (@(posedge aclk) disable iff (!aresetn)
    blk_valid && blk_ready && idx_q == 3'h2 && req_q.kind == `TSB_KIND_OPEN
    |-> blk_data == WQ_CAP ##1 blk_data == RQ_CAP)
    else $error("Queue capacities wrong.");

  a_notice_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    launch && cmd_kind == `TSB_KIND_NOTICE |-> allow_q && allow_chan_q == chan_q)
    else $error("Notice launched on a channel without permission.");

  a_notice_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_wr && (cmd_kind > 3'h4 || (cmd_kind == `TSB_KIND_NOTICE &&
    !(allow_q && allow_chan_q == chan_q))) |=> refused_q && state_q != ST_BUILD)
    else $error("Refused command was not flagged or still launched.");
endmodule

// *** tb/tsb_blk_sink.sv ***
// Initiator-side sink that takes status quadlets promptly or with random stalls.
module tsb_blk_sink (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic blk_valid,
  input wire logic [31:0] blk_data,
  input wire logic blk_last,
  input wire logic hold,
  input wire logic slow,
  output logic blk_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [32:0] got [$];
  // Ready is registered and may drop at any edge, so the builder must hold its quadlet.
  always @(posedge aclk) begin
    if (!aresetn) begin
      blk_ready <= 1'b0;
    end else begin
      blk_ready <= !hold && (!slow || $urandom_range(1, 0) == 1);
      // The tag is stored raw; the bench compares it with the expected quadlet for every block kind.
      if (blk_valid && blk_ready) begin
        got.push_back({blk_last, blk_data});
      end
    end
  end
endmodule

// *** tb/transport_status_block_builder_tb.sv ***
// Bench of the status block builder: bus tasks, block model and compares.
`include "tsb_params.svh"
module transport_status_block_builder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] WQ = 32'h0000_0010;
  localparam logic [31:0] RQ = 32'h0000_0004;
  localparam logic [1:0] OK = `TSB_RESP_OKAY;
  localparam logic [1:0] DE = `TSB_RESP_DECERR;
  localparam logic [7:0] FN [5] = '{`TSB_FN_WRITE, `TSB_FN_READ, `TSB_FN_NOTICE,
                                    `TSB_FN_OPEN, `TSB_FN_CLOSE};
  localparam logic [2:0] ORD [6] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h4, 3'h2};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic hold = 1'b0;
  logic slow = 1'b0;
  logic [3:0] strb_sel = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic blk_valid, blk_ready, blk_last, busy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, blk_data;
  logic allow = 1'b0;
  logic [15:0] allow_ch = 16'h0000;
  logic [32:0] eq [$];
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  ////////////////////////////////////////////////////////////////////////////////
  always #10 aclk = ~aclk;
  tsb_status_builder #(.WQ_CAP(WQ), .RQ_CAP(RQ)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .blk_valid(blk_valid), .blk_ready(blk_ready), .blk_data(blk_data),
    .blk_last(blk_last), .busy(busy)
  );
  tsb_blk_sink snk (
    .aclk(aclk), .aresetn(aresetn), .blk_valid(blk_valid), .blk_data(blk_data),
    .blk_last(blk_last), .hold(hold), .slow(slow), .blk_ready(blk_ready)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (fail_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk_r(input string w, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk_q(input string w, input logic [32:0] e, input logic [32:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask
  // Ready is looked at on the falling edge, so the next rising edge is the handshake.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= strb_sel;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta || awready === 1'b1;
      tw = tw || wready === 1'b1;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    chk_r("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
                    input logic [31:0] m);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    chk_r("rresp", {30'h0, er}, {30'h0, rresp});
    chk_r("rdata", e & m, rdata & m);
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // Small channel pool so that notices sometimes hit the allowed channel.
  task automatic launch(input logic [2:0] k, input logic st, input logic al);
    logic [15:0] ch;
    logic [15:0] pe;
    logic [31:0] res;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] q [6];
    logic ok;
    ch = ($urandom_range(3, 0) != 0) ? 16'h1122 : 16'($urandom);
    pe = ($urandom_range(3, 0) != 0) ? 16'h1122 : 16'($urandom);
    res = $urandom;
    lo = $urandom;
    hi = $urandom;
    if ($urandom_range(1, 0) == 1) res[6:0] = 7'h00;
    wr(`TSB_OFS_CHAN, {16'h0, ch}, OK);
    wr(`TSB_OFS_RESULT, res, OK);
    wr(`TSB_OFS_CNT_LO, lo, OK);
    wr(`TSB_OFS_CNT_HI, hi, OK);
    wr(`TSB_OFS_PEER, {16'h0, pe}, OK);
    ok = (k != 3'h2) || (allow && ch == allow_ch);
    q[0] = {(k > 3'h2) ? `TSB_MGMT_ID : ch, FN[k], (k == 3'h1) && res[8], res[6:0]};
    q[1] = (k > 3'h2) ? {pe, 16'h0} : {16'h0, hi[15:0]};
    q[2] = (k == 3'h3) ? WQ : (k == 3'h4) ? 32'h0 : lo;
    q[3] = (k == 3'h3) ? RQ : 32'h0;
    q[4] = 32'h0;
    q[5] = 32'h0;
    if (st) begin
      @(posedge aclk);
      hold <= 1'b1;
    end
    wr(`TSB_OFS_CMD, {23'h0, al, 5'h0, k}, OK);
    if (ok) for (int i = 0; i < 6; i++) eq.push_back({i == 5, q[i]});
    if (k == 3'h3) begin
      allow = al;
      allow_ch = pe;
    end
    if (k == 3'h4 && pe == allow_ch) allow = 1'b0;
    rd(`TSB_OFS_STAT, {allow_ch, 13'h0, allow, !ok, 1'b0}, OK, 32'hFFFF_0006);
    if (st) begin
      wr(`TSB_OFS_CMD, 32'h0000_0001, OK);
      rd(`TSB_OFS_STAT, 32'h0000_0003, OK, 32'h0000_0003);
      rd(`TSB_OFS_CMD, 32'h0000_0001, OK, '1);
      @(posedge aclk);
      hold <= 1'b0;
    end
    repeat (10) @(negedge aclk);
    while (snk.got.size() < eq.size()) @(negedge aclk);
    repeat (2) @(negedge aclk);
    chk_r("blocks", eq.size(), snk.got.size());
    chk_r("busy", 32'h0, {31'h0, busy});
    while (eq.size() > 0) begin
      chk_q("quadlet", eq.pop_front(), snk.got.pop_front());
    end
    snk.got.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // A run takes under two thousand cycles; the ceiling leaves ample margin.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    void'($urandom(18));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`TSB_OFS_WQCAP, WQ, OK, '1);
    rd(`TSB_OFS_RQCAP, RQ, OK, '1);
    rd(`TSB_OFS_STAT, 32'h0, OK, '1);
    wr(`TSB_OFS_RQCAP, 32'h0000_00FF, OK);
    rd(`TSB_OFS_RQCAP, RQ, OK, '1);
    wr(8'h40, 32'h0000_0001, DE);
    rd(8'h40, 32'h0, DE, '1);
    wr(`TSB_OFS_CHAN, 32'h0000_ABCD, OK);
    rd(`TSB_OFS_CHAN, 32'h0000_ABCD, OK, '1);
    strb_sel = 4'h2;
    wr(`TSB_OFS_CHAN, 32'h0000_3300, OK);
    strb_sel = 4'hF;
    rd(`TSB_OFS_CHAN, 32'h0000_33CD, OK, '1);
    wr(`TSB_OFS_CMD, 32'h0000_0005, OK);
    rd(`TSB_OFS_STAT, 32'h0000_0002, OK, '1);
    launch(3'h0, 1'b1, 1'b0);
    for (int i = 0; i < 30; i++) begin
      slow <= i[0];
      launch(ORD[i % 6], 1'b0, (i / 6) % 2 == 1);
    end
    test_done();
  end
endmodule
